// file: wdf_pkg.sv
// Package for the wakeup detect and flag signalling block.
// Assumes a 40 MHz system clock; all filter times are counted in its cycles.
package wdf_pkg;

	// Timebase
	localparam int CLK_MHZ = 40;
	// Bus phase threshold in microseconds, least time so rounded up
	localparam int BUS_PHASE_US = 5;
	localparam int BUS_PHASE_CYC = BUS_PHASE_US * CLK_MHZ;
	// Local trigger filter time in microseconds, plain default
	localparam int WAKE_FILT_US = 50;
	localparam int WAKE_FILT_CYC = WAKE_FILT_US * CLK_MHZ;
	// Counter width covers both counts
	localparam int CNT_W = 12;

	// Reset values
	localparam logic WAKE_FLAG_RST = 1'b0;
	localparam logic BIAS_RST = 1'b0;

	// Operating modes as decoded from the two mode inputs
	typedef enum logic [2:0] {
		WDF_MODE_NORMAL,
		WDF_MODE_LISTEN,
		WDF_MODE_SLEEP_REQ,
		WDF_MODE_STANDBY,
		WDF_MODE_SLEEP
	} wdf_mode_t;

	// Supply monitor inputs
	typedef struct packed {
		logic transceiver_rail_ok;
		logic io_rail_ok;
		logic battery_rail_uv;
	} wdf_supply_t;

	// Other status flags shown on the fault status pin
	typedef struct packed {
		logic pwon;
		logic wake_src_local;
		logic bus_failure;
		logic local_failure;
	} wdf_flags_t;

endpackage : wdf_pkg

// file: wdf_filter.sv
// Time filter: output follows input once it has held a new level long enough.
// Assumes the input is already synchronised to clk_sys_i.
`timescale 1ns/1ps
module wdf_filter
	import wdf_pkg::*;
#(
	parameter logic [CNT_W-1:0] HOLD_CYC = CNT_W'(WAKE_FILT_CYC)
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic level_i,
	output logic level_o,
	output logic change_o
);

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic next_level_o;

	// Count while the input differs from the filtered level
	always_comb begin
		next_count = '0;
		next_level_o = level_o;
		change_o = 1'b0;
		if (level_i != level_o) begin
			if (count >= HOLD_CYC - CNT_W'(1)) begin
				next_level_o = level_i;
				change_o = 1'b1;
			end else begin
				next_count = count + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count <= '0;
			level_o <= BIAS_RST;
		end else begin
			count <= next_count;
			level_o <= next_level_o;
		end
	end

endmodule : wdf_filter

// file: wdf_wakeup.sv
// Wakeup detection and flag signalling for a CAN transceiver.
// Assumes modes decoded elsewhere; pins and supply monitors are asynchronous.
//
// Overview of operation
// R1: Bus or local pin wakes set flag
// R2: Single pattern: dominant 5 us wakes
// R3: Enhanced: two dominant-recessive 5 us pairs
// R4: Parameter selects single or two-phase pattern
// R5: Filtered local pin level change wakes
// R6: Bias follows filtered local pin level
// R7: Low pulse wakes and biases to ground
// R8: Five flags share the fault pin
// R9: Mode and history select the shown flag
// R10: Host waits 10 us before sampling
// R11: Flag set only in low-power modes
// R12: Fault pin low while flag set
// R13: Normal entry or battery undervoltage clears
// R14: Set flag blocks sleep entry
// R15: Receive pin shows flag, active low
// R16: Host drives mode-control inputs
// R17: Fault pin is push-pull
// R18: Filter times counted in clock cycles
`timescale 1ns/1ps
module wdf_wakeup
	import wdf_pkg::*;
#(
	parameter bit ENHANCED_PATTERN = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic bus_dominant_i,
	input wire logic local_wake_i,
	input wire wdf_mode_t mode_i,
	input wire logic sleep_request_mode_i,
	input wire wdf_supply_t supply_i,
	input wire wdf_flags_t flags_i,
	input wire logic rx_data_i,
	output logic wake_flag_o,
	output logic sleep_allowed_o,
	output logic local_bias_high_o,
	output logic fault_status_pin_o,
	output logic fault_status_pin_oe_o,
	output logic rx_data_o
);

	localparam logic [CNT_W-1:0] PHASE_CYC = CNT_W'(BUS_PHASE_CYC);

	typedef enum logic [2:0] {
		WDF_BUS_IDLE,
		WDF_BUS_DOM1,
		WDF_BUS_REC1,
		WDF_BUS_DOM2,
		WDF_BUS_REC2
	} wdf_bus_st_t;

	// Two-flop synchronisers; stage one feeds only stage two
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic bus_dom;
	logic wake_pin;
	logic uv;
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else begin
			sync_a <= {supply_i.battery_rail_uv, local_wake_i, bus_dominant_i};
			sync_b <= sync_a;
		end
	end
	assign bus_dom = sync_b[0];
	assign wake_pin = sync_b[1];
	assign uv = sync_b[2];

	// Low-power modes are where wake events count
	function automatic logic low_power(input wdf_mode_t m);
		low_power = (m == WDF_MODE_SLEEP) || (m == WDF_MODE_STANDBY) ||
			(m == WDF_MODE_SLEEP_REQ);
	endfunction : low_power

	// Local trigger filter; bias tracks the filtered level
	logic pin_change;
	wdf_filter #(
		.HOLD_CYC(CNT_W'(WAKE_FILT_CYC))
	) u_filter (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.level_i(wake_pin),
		.level_o(local_bias_high_o), // see R6 see R7
		.change_o(pin_change)
	);
	logic local_wake;
	assign local_wake = pin_change; // see R5 see R7

	// Bus pattern detector
	wdf_bus_st_t bus_st;
	wdf_bus_st_t next_bus_st;
	logic [CNT_W-1:0] phase_cnt;
	logic [CNT_W-1:0] next_phase_cnt;
	logic bus_wake;
	logic phase_done;
	assign phase_done = (phase_cnt >= PHASE_CYC - CNT_W'(1)); // see R18

	// Count each phase; a too-short phase restarts the pattern
	always_comb begin
		next_bus_st = bus_st;
		next_phase_cnt = phase_cnt;
		bus_wake = 1'b0;
		unique case (bus_st)
			WDF_BUS_IDLE: begin
				next_phase_cnt = '0;
				if (bus_dom) begin
					next_bus_st = WDF_BUS_DOM1;
				end
			end
			WDF_BUS_DOM1, WDF_BUS_DOM2: begin
				if (!bus_dom) begin
					next_phase_cnt = '0;
					next_bus_st = WDF_BUS_IDLE;
					if (phase_cnt == PHASE_CYC) begin
						next_bus_st = (bus_st == WDF_BUS_DOM1) ? WDF_BUS_REC1 : WDF_BUS_REC2;
					end
				end else if (!phase_done) begin
					next_phase_cnt = phase_cnt + CNT_W'(1);
				end else if (phase_cnt != PHASE_CYC) begin
					next_phase_cnt = PHASE_CYC;
					if (!ENHANCED_PATTERN) begin // see R4
						bus_wake = 1'b1; // see R2
						next_bus_st = WDF_BUS_IDLE;
					end
				end
			end
			WDF_BUS_REC1, WDF_BUS_REC2: begin
				if (bus_dom) begin
					next_phase_cnt = '0;
					next_bus_st = WDF_BUS_DOM1;
					if (phase_cnt == PHASE_CYC && bus_st == WDF_BUS_REC1) begin
						next_bus_st = WDF_BUS_DOM2;
					end
				end else if (!phase_done) begin
					next_phase_cnt = phase_cnt + CNT_W'(1);
				end else begin
					next_phase_cnt = PHASE_CYC;
					if (bus_st == WDF_BUS_REC2) begin
						bus_wake = 1'b1; // see R3
						next_bus_st = WDF_BUS_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus_st <= WDF_BUS_IDLE;
			phase_cnt <= '0;
		end else begin
			bus_st <= next_bus_st;
			phase_cnt <= next_phase_cnt;
		end
	end

	// Wakeup flag; a wake in an undervoltage clearing cycle wins so no event is lost,
	// but a held undervoltage clears it again on the next cycle
	logic next_wake_flag;
	always_comb begin
		next_wake_flag = wake_flag_o;
		if (uv || mode_i == WDF_MODE_NORMAL) begin
			next_wake_flag = 1'b0; // see R13
		end
		if ((bus_wake || local_wake) && low_power(mode_i)) begin
			next_wake_flag = 1'b1; // see R1 see R11
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wake_flag_o <= WAKE_FLAG_RST;
		end else begin
			wake_flag_o <= next_wake_flag;
		end
	end

	// Sleep blocked while flag or power-on flag is set
	assign sleep_allowed_o = sleep_request_mode_i && !wake_flag_o && !flags_i.pwon; // see R14

	// Previous mode keeps the history needed to choose the shown flag
	wdf_mode_t prev_mode;
	wdf_mode_t next_prev_mode;
	logic next_fault;
	logic next_rx;
	logic fault_q;
	logic rx_q;
	logic rails_ok;
	assign rails_ok = supply_i.transceiver_rail_ok && supply_i.io_rail_ok;

	// Flag selection by mode and history; pin levels are active low
	always_comb begin
		next_prev_mode = prev_mode;
		if (mode_i != WDF_MODE_LISTEN) begin
			next_prev_mode = mode_i;
		end
		next_fault = 1'b1;
		next_rx = rx_data_i;
		unique case (mode_i)
			WDF_MODE_NORMAL: begin
				next_fault = !(flags_i.bus_failure || flags_i.wake_src_local); // see R8 see R9
			end
			WDF_MODE_LISTEN: begin
				if (prev_mode == WDF_MODE_NORMAL) begin
					next_fault = !flags_i.local_failure; // see R9
				end else begin
					next_fault = !flags_i.pwon; // see R9
				end
			end
			WDF_MODE_SLEEP_REQ, WDF_MODE_STANDBY, WDF_MODE_SLEEP: begin
				next_fault = !wake_flag_o; // see R12
				next_rx = !wake_flag_o; // see R15
			end
			default: begin
				next_fault = 1'b1; // Illegal mode code shows no flag
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_mode <= WDF_MODE_NORMAL;
			fault_q <= 1'b1;
			rx_q <= 1'b1;
		end else begin
			prev_mode <= next_prev_mode;
			fault_q <= next_fault;
			rx_q <= next_rx;
		end
	end

	// Push-pull: always driven while rails are present
	assign fault_status_pin_o = fault_q; // see R17
	assign fault_status_pin_oe_o = rails_ok || !low_power(mode_i); // see R12
	assign rx_data_o = rx_q;

	// Check helpers: saturating run lengths of the synchronised bus level
	logic [CNT_W-1:0] dom_run;
	logic [CNT_W-1:0] rec_run;
	logic [CNT_W-1:0] next_dom_run;
	logic [CNT_W-1:0] next_rec_run;
	always_comb begin
		next_dom_run = '0;
		next_rec_run = '0;
		if (bus_dom) begin
			next_dom_run = (dom_run == PHASE_CYC) ? dom_run : dom_run + CNT_W'(1);
		end else begin
			next_rec_run = (rec_run == PHASE_CYC) ? rec_run : rec_run + CNT_W'(1);
		end
	end

	// Run lengths registered; they only feed the checks below
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dom_run <= '0;
			rec_run <= '0;
		end else begin
			dom_run <= next_dom_run;
			rec_run <= next_rec_run;
		end
	end

	// Checks; each is held off while reset is applied
	chk_flag_set_lp: assert property (@(posedge clk_sys_i) // see R11
		disable iff (sys_rst_i) $rose(wake_flag_o) |-> $past(low_power(mode_i)))
		else $error("wake flag set outside low-power mode");
	chk_flag_clear_norm: assert property (@(posedge clk_sys_i) // see R13
		disable iff (sys_rst_i) (mode_i == WDF_MODE_NORMAL) |=> !wake_flag_o)
		else $error("wake flag not cleared in normal mode");
	chk_sleep_blocked: assert property (@(posedge clk_sys_i) // see R14
		disable iff (sys_rst_i) wake_flag_o |-> !sleep_allowed_o)
		else $error("sleep allowed with wake flag set");
	chk_fault_pin_lp: assert property (@(posedge clk_sys_i) // see R12
		disable iff (sys_rst_i) low_power(mode_i) |=> (fault_q == !$past(wake_flag_o)))
		else $error("fault pin does not show wake flag");
	chk_rx_pin_lp: assert property (@(posedge clk_sys_i) // see R15
		disable iff (sys_rst_i) (low_power(mode_i) && wake_flag_o) |=> !rx_q)
		else $error("receive pin not low with wake flag");
	chk_bus_wake_set: assert property (@(posedge clk_sys_i) // see R1
		disable iff (sys_rst_i) (bus_wake && low_power(mode_i)) |=> wake_flag_o)
		else $error("bus wake did not set flag");
	chk_local_wake_set: assert property (@(posedge clk_sys_i) // see R5
		disable iff (sys_rst_i) (local_wake && low_power(mode_i)) |=> wake_flag_o)
		else $error("local wake did not set flag");
	chk_bias_follow: assert property (@(posedge clk_sys_i) // see R6
		disable iff (sys_rst_i) local_wake |=> (local_bias_high_o == $past(wake_pin)))
		else $error("bias does not follow filtered level");
	chk_bus_min_time: assert property (@(posedge clk_sys_i) // see R2
		disable iff (sys_rst_i) (bus_wake && !ENHANCED_PATTERN) |-> (dom_run == PHASE_CYC))
		else $error("bus wake before dominant time");
	chk_enh_rec_time: assert property (@(posedge clk_sys_i) // see R3
		disable iff (sys_rst_i) (bus_wake && ENHANCED_PATTERN) |-> (rec_run == PHASE_CYC))
		else $error("two-phase wake before recessive time");
	chk_uv_clears: assert property (@(posedge clk_sys_i) // see R13
		disable iff (sys_rst_i) (uv && !bus_wake && !local_wake) |=> !wake_flag_o)
		else $error("wake flag not cleared by undervoltage");
	chk_listen_holds: assert property (@(posedge clk_sys_i) // see R11
		disable iff (sys_rst_i) (mode_i == WDF_MODE_LISTEN && !uv) |=> $stable(wake_flag_o))
		else $error("wake flag changed in listen mode");

endmodule : wdf_wakeup

// file: wdf_partner.sv
// Far-side model: bus nodes making dominant and recessive phases, and the host pins.
// Assumes its tasks are called from one process, clocked by clk_sys_i.
`timescale 1ns/1ps
module wdf_partner
	import wdf_pkg::*;
(
	input wire logic clk_sys_i,
	output logic bus_dominant_o,
	output logic local_wake_o,
	output wdf_mode_t mode_o
);
	// Bus idles recessive, local pin tied low, host starts in sleep
	initial begin
		bus_dominant_o = 1'b0;
		local_wake_o = 1'b0;
		mode_o = WDF_MODE_SLEEP;
	end

	// One bus phase held for n cycles
	task automatic phase(input logic dom, input int n);
		@(posedge clk_sys_i);
		bus_dominant_o <= dom;
		repeat (n) @(posedge clk_sys_i);
	endtask : phase

	// Local trigger pin held at a level for n cycles
	task automatic pin(input logic lvl, input int n);
		@(posedge clk_sys_i);
		local_wake_o <= lvl;
		repeat (n) @(posedge clk_sys_i);
	endtask : pin

	// Host port pins pick the mode; 400 cycles pass before the fault pin is read
	task automatic set_mode(input wdf_mode_t m);
		@(posedge clk_sys_i);
		mode_o <= m;
		repeat (400) @(posedge clk_sys_i);
	endtask : set_mode
endmodule : wdf_partner

// file: tb_wdf_wakeup.sv
// Self-checking bench for the wakeup detect block, both bus patterns side by side.
// Assumes wdf_partner drives the bus, the local pin and the mode inputs.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
	$display("BAD %0t value mismatch", $time); end end
module tb_wdf_wakeup;
	import wdf_pkg::*;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic sleep_request_mode_i = 1'b1;
	logic rx_data_i = 1'b1;
	wdf_supply_t supply_i = 3'b110;
	wdf_flags_t flags = '0;
	logic bus_dom, wake_pin, flag, allowed, bias, fault, fault_oe, rx, flag_enh;
	wdf_mode_t mode;
	int bad_count = 0;
	int compares = 0;

	// 40 MHz clock
	always #12.5 clk_sys_i = ~clk_sys_i;

	wdf_partner u_far (.clk_sys_i(clk_sys_i), .bus_dominant_o(bus_dom),
		.local_wake_o(wake_pin), .mode_o(mode));
	wdf_wakeup #(.ENHANCED_PATTERN(1'b0)) uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.bus_dominant_i(bus_dom), .local_wake_i(wake_pin), .mode_i(mode),
		.sleep_request_mode_i(sleep_request_mode_i), .supply_i(supply_i), .flags_i(flags),
		.rx_data_i(rx_data_i), .wake_flag_o(flag), .sleep_allowed_o(allowed),
		.local_bias_high_o(bias), .fault_status_pin_o(fault),
		.fault_status_pin_oe_o(fault_oe), .rx_data_o(rx));
	// Second copy only watches its flag, to compare the two-phase pattern
	wdf_wakeup #(.ENHANCED_PATTERN(1'b1)) uut_enh (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .bus_dominant_i(bus_dom), .local_wake_i(wake_pin),
		.mode_i(mode), .sleep_request_mode_i(sleep_request_mode_i), .supply_i(supply_i),
		.flags_i('0), .rx_data_i(rx_data_i), .wake_flag_o(flag_enh), .sleep_allowed_o(),
		.local_bias_high_o(), .fault_status_pin_o(), .fault_status_pin_oe_o(),
		.rx_data_o());

	// Verdict and end of run
	task automatic complete_run();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	// Hang guard, far above the longest sequence
	initial begin
		repeat (50000) @(posedge clk_sys_i);
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		repeat (5) @(negedge clk_sys_i);
		`CHK(flag, 1'b0)
		`CHK(fault, 1'b1)
		`CHK(fault_oe, 1'b1)
		`CHK(rx, 1'b1)
		$display("test reset done");
		// Too short a dominant phase must not wake
		u_far.phase(1'b1, 100);
		u_far.phase(1'b0, 50);
		@(negedge clk_sys_i);
		`CHK(flag, 1'b0)
		// One long dominant phase wakes only the single-pattern copy
		u_far.phase(1'b1, 220);
		u_far.phase(1'b0, 220);
		@(negedge clk_sys_i);
		`CHK(flag, 1'b1)
		`CHK(fault, 1'b0)
		`CHK(fault_oe, 1'b1)
		`CHK(rx, 1'b0)
		`CHK(allowed, 1'b0)
		`CHK(flag_enh, 1'b0)
		u_far.phase(1'b1, 220);
		u_far.phase(1'b0, 220);
		@(negedge clk_sys_i);
		`CHK(flag_enh, 1'b1)
		$display("test bus wake done");
		// Normal entry clears; wakes in normal are ignored
		u_far.set_mode(WDF_MODE_NORMAL);
		@(negedge clk_sys_i);
		`CHK(flag, 1'b0)
		`CHK(flag_enh, 1'b0)
		u_far.phase(1'b1, 300);
		u_far.phase(1'b0, 20);
		@(negedge clk_sys_i);
		`CHK(flag, 1'b0)
		`CHK(allowed, 1'b1)
		$display("test normal mode done");
		// Local pin rises and holds past the filter in standby
		u_far.set_mode(WDF_MODE_STANDBY);
		@(negedge clk_sys_i);
		`CHK(flag, 1'b0)
		u_far.pin(1'b1, 2100);
		@(negedge clk_sys_i);
		`CHK(bias, 1'b1)
		`CHK(flag, 1'b1)
		// Battery undervoltage clears, then a low pulse wakes again
		@(posedge clk_sys_i);
		supply_i.battery_rail_uv <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		supply_i.battery_rail_uv <= 1'b0;
		@(negedge clk_sys_i);
		`CHK(flag, 1'b0)
		u_far.pin(1'b0, 2100);
		@(negedge clk_sys_i);
		`CHK(bias, 1'b0)
		`CHK(flag, 1'b1)
		`CHK(fault, 1'b0)
		$display("test local wake done");
		// Rails gone: fault pin released in a low-power mode
		@(posedge clk_sys_i);
		supply_i.transceiver_rail_ok <= 1'b0;
		@(negedge clk_sys_i);
		`CHK(fault_oe, 1'b0)
		@(posedge clk_sys_i);
		supply_i.transceiver_rail_ok <= 1'b1;
		flags <= 4'h8;
		// Sleep request with the flag set is refused
		u_far.set_mode(WDF_MODE_SLEEP_REQ);
		@(negedge clk_sys_i);
		`CHK(allowed, 1'b0)
		`CHK(fault, 1'b0)
		// Listen after a low-power mode shows power-on; flag is kept
		u_far.set_mode(WDF_MODE_LISTEN);
		@(negedge clk_sys_i);
		`CHK(fault, 1'b0)
		`CHK(flag, 1'b1)
		// Normal shows the bus failure flag and passes receive data
		@(posedge clk_sys_i);
		flags <= 4'h2;
		rx_data_i <= 1'b0;
		u_far.set_mode(WDF_MODE_NORMAL);
		@(negedge clk_sys_i);
		`CHK(fault, 1'b0)
		`CHK(rx, 1'b0)
		`CHK(flag, 1'b0)
		// Listen after normal shows the local failure flag; wakes ignored
		@(posedge clk_sys_i);
		flags <= 4'h8;
		u_far.set_mode(WDF_MODE_LISTEN);
		@(negedge clk_sys_i);
		`CHK(fault, 1'b1)
		u_far.pin(1'b1, 2100);
		@(negedge clk_sys_i);
		`CHK(bias, 1'b1)
		`CHK(flag, 1'b0)
		// Power-on flag alone also blocks sleep
		u_far.set_mode(WDF_MODE_SLEEP_REQ);
		@(negedge clk_sys_i);
		`CHK(allowed, 1'b0)
		`CHK(fault, 1'b1)
		`CHK(rx, 1'b1)
		@(posedge clk_sys_i);
		flags <= 4'h0;
		@(negedge clk_sys_i);
		`CHK(allowed, 1'b1)
		$display("test flag select done");
		complete_run();
	end
endmodule : tb_wdf_wakeup
